//--- core/mcl_core.sv
// What this block does
// - field angle follows demanded position times pole pair count, default 50
// - commanded winding current never exceeds motor protection limit in mA
// - rated current in mA is reference for the permille maximum current
// - maximum current in permille of rated, default 1000, writes clamped to 1000
// - submode bit 0 low selects open loop, high selects closed loop
// - standstill current reduction only while submode bit 3 is set
// - reduction starts after set position unchanged for idle time in ms
// - reduced open-loop standstill current is configured reduction value
// - position, velocity and current PI stages in cascade
// - current stage runs in every mode
// - velocity stage skipped in open loop and in torque modes with submode bit 5
// - position stage in position modes, velocity modes when bit 1 set
// - legacy gains by default; converted at power-on when legacy bit clear
// - outputs clamped to max speed, max current, max pwm
// - max deviation at 100 percent gain gives max output, proportional below
// - proportional output scales linearly with gain factor
// - smaller reset time gives faster integral; zero reset time disables it
// - step/direction resolution scaled by multiplier over divider, at most one count per step
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mcl_core #(
    parameter int PERIOD_CYC = mcl_pkg::PERIOD_CYC,
    parameter int MS_CYC = mcl_pkg::MS_CYC
) (
    input wire logic CLOCK_I,
    input wire logic ARST_N_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic signed [31:0] ACT_POS_I,
    input wire logic signed [31:0] ACT_VEL_I,
    input wire logic signed [31:0] ACT_CUR_I,
    input wire logic STEP_I,
    input wire logic DIR_I,
    output logic signed [31:0] PWM_O,
    output logic signed [31:0] CUR_SET_O,
    output logic [15:0] ELEC_ANGLE_O,
    output logic REDUCE_O
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] regs_r [0:31];
    logic signed [31:0] acc_r [0:2];
    logic [7:0] aw_a_r;
    logic [31:0] w_d_r;
    logic [3:0] w_s_r;
    logic wr_go, wr_ok;
    logic [4:0] wi;
    logic [31:0] wmask, wval;
    always_comb begin
        wr_go = !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
        wi = aw_a_r[6:2];
        wr_ok = aw_a_r[7] == 1'b0 && aw_a_r[1:0] == 2'b00 &&
                (aw_a_r < mcl_pkg::A_STATUS);
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{w_s_r[b]}};
        end
        wval = (regs_r[wi] & ~wmask) | (w_d_r & wmask);
    end

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O <= 1'b1;
            aw_a_r <= 8'h00;
            w_d_r <= 32'h0000_0000;
            w_s_r <= 4'h0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= 2'b00;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                S_AXI_AWREADY_O <= 1'b0;
                aw_a_r <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                S_AXI_WREADY_O <= 1'b0;
                w_d_r <= S_AXI_WDATA_I;
                w_s_r <= S_AXI_WSTRB_I;
            end
            if (wr_go) begin
                S_AXI_AWREADY_O <= 1'b1;
                S_AXI_WREADY_O <= 1'b1;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= wr_ok ? 2'b00 : 2'b10;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // configuration
    // ----------------------------------------
    logic conv_r;
    logic new_par_r;
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            for (int i = 0; i < 32; i++) begin
                regs_r[i] <= 32'h0000_0000;
            end
            regs_r[mcl_pkg::A_POLES[6:2]] <= mcl_pkg::RST_POLES;
            regs_r[mcl_pkg::A_PERMILLE[6:2]] <= mcl_pkg::PERMILLE_MAX;
            regs_r[mcl_pkg::A_LEGACY[6:2]] <= mcl_pkg::RST_LEGACY;
            regs_r[mcl_pkg::A_CDMUL[6:2]] <= mcl_pkg::RST_ONE;
            regs_r[mcl_pkg::A_CDDIV[6:2]] <= mcl_pkg::RST_ONE;
        end else begin
            regs_r[0][1] <= 1'b0;
            if (wr_go && wr_ok) begin
                if (wi == mcl_pkg::A_PERMILLE[6:2] &&
                    wval > mcl_pkg::PERMILLE_MAX) begin
                    regs_r[wi] <= mcl_pkg::PERMILLE_MAX;
                end else begin
                    regs_r[wi] <= wval;
                end
            end
            // legacy gain in LEGACY[31:16] copied to every stage
            if (conv_r) begin
                for (int s = 0; s < 3; s++) begin
                    regs_r[16 + 4*s] <= {16'h0000,
                        regs_r[mcl_pkg::A_LEGACY[6:2]][31:16]};
                end
            end
        end
    end

    logic [31:0] submode, ctrl, legacy;
    logic [7:0] opmode;
    logic closed, pos_act, vel_act, torque_md, vel_md;
    always_comb begin
        submode = regs_r[mcl_pkg::A_SUBMODE[6:2]];
        ctrl = regs_r[mcl_pkg::A_CTRL[6:2]];
        legacy = regs_r[mcl_pkg::A_LEGACY[6:2]];
        opmode = regs_r[mcl_pkg::A_OPMODE[6:2]][7:0];
        closed = submode[mcl_pkg::SM_LOOP];
        torque_md = opmode == mcl_pkg::OM_TQ || opmode == mcl_pkg::OM_CST;
        vel_md = opmode == mcl_pkg::OM_VL || opmode == mcl_pkg::OM_PV ||
                 opmode == mcl_pkg::OM_CSV;
        pos_act = opmode == mcl_pkg::OM_PP || opmode == mcl_pkg::OM_HM ||
                  opmode == mcl_pkg::OM_IP || opmode == mcl_pkg::OM_CSP ||
                  opmode == mcl_pkg::OM_CD ||
                  (vel_md && submode[mcl_pkg::SM_VPOS]);
        vel_act = !(torque_md && submode[mcl_pkg::SM_RTQ]);
    end

    // conversion runs once after reset release and on a soft restart
    logic boot_r;
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            boot_r <= 1'b1;
            conv_r <= 1'b0;
            new_par_r <= 1'b0;
        end else begin
            boot_r <= 1'b0;
            conv_r <= 1'b0;
            if (boot_r || ctrl[1]) begin
                if (!(closed ? legacy[mcl_pkg::LG_CL]
                             : legacy[mcl_pkg::LG_OL])) begin
                    conv_r <= 1'b1;
                    new_par_r <= 1'b1;
                end else begin
                    new_par_r <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // current limits
    // ----------------------------------------
    logic [42:0] rated_x;
    logic [31:0] eff_max, lim;
    always_comb begin
        rated_x = 43'(regs_r[mcl_pkg::A_RATED[6:2]]) *
                  43'(regs_r[mcl_pkg::A_PERMILLE[6:2]][10:0]);
        eff_max = 32'(rated_x / 43'(mcl_pkg::PERMILLE_MAX));
        lim = regs_r[mcl_pkg::A_LIMIT[6:2]];
        if (eff_max > lim) begin
            eff_max = lim;
        end
        eff_max[31] = 1'b0;
    end

    // ----------------------------------------
    // step/direction input
    // ----------------------------------------
    logic [2:0] stp_r;
    logic [1:0] dir_r;
    logic [31:0] frac_r;
    logic signed [31:0] cd_pos_r;
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            stp_r <= 3'h0;
            dir_r <= 2'h0;
            frac_r <= 32'h0000_0000;
            cd_pos_r <= 32'sh0000_0000;
        end else begin
            stp_r <= {stp_r[1:0], STEP_I};
            dir_r <= {dir_r[0], DIR_I};
            // one position count per step at most; ratio above 1 caps
            if (stp_r[1] && !stp_r[2]) begin
                if (frac_r + regs_r[mcl_pkg::A_CDMUL[6:2]] >=
                    regs_r[mcl_pkg::A_CDDIV[6:2]]) begin
                    frac_r <= frac_r + regs_r[mcl_pkg::A_CDMUL[6:2]] -
                              regs_r[mcl_pkg::A_CDDIV[6:2]];
                    cd_pos_r <= dir_r[1] ? cd_pos_r - 32'sd1
                                         : cd_pos_r + 32'sd1;
                end else begin
                    frac_r <= frac_r + regs_r[mcl_pkg::A_CDMUL[6:2]];
                end
            end
        end
    end

    // ----------------------------------------
    // standstill current reduction
    // ----------------------------------------
    logic signed [31:0] dpos, dpos_r;
    logic [16:0] tick_cnt_r, ms_cnt_r;
    logic [31:0] idle_r;
    logic tick, ms_tick, reduce_r;
    assign dpos = opmode == mcl_pkg::OM_CD ? cd_pos_r
                : $signed(regs_r[mcl_pkg::A_TPOS[6:2]]);
    assign tick = tick_cnt_r == 17'(PERIOD_CYC - 1);
    assign ms_tick = ms_cnt_r == 17'(MS_CYC - 1);
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tick_cnt_r <= 17'h0_0000;
            ms_cnt_r <= 17'h0_0000;
        end else begin
            tick_cnt_r <= tick ? 17'h0_0000 : tick_cnt_r + 17'h0_0001;
            ms_cnt_r <= ms_tick ? 17'h0_0000 : ms_cnt_r + 17'h0_0001;
        end
    end
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            dpos_r <= 32'sh0000_0000;
            idle_r <= 32'h0000_0000;
            reduce_r <= 1'b0;
        end else begin
            dpos_r <= dpos;
            if (dpos != dpos_r) begin
                idle_r <= 32'h0000_0000;
            end else if (ms_tick && idle_r != 32'hFFFF_FFFF) begin
                idle_r <= idle_r + 32'h0000_0001;
            end
            reduce_r <= submode[mcl_pkg::SM_RED] && !closed &&
                        dpos == dpos_r &&
                        idle_r >= regs_r[mcl_pkg::A_IDLE[6:2]];
        end
    end

    // ----------------------------------------
    // shared PI datapath
    // ----------------------------------------
    function automatic logic signed [31:0] sat(
        input logic signed [63:0] v, input logic [31:0] m);
        logic signed [63:0] mx;
        mx = $signed({32'h0000_0000, 1'b0, m[30:0]});
        if (v > mx) return mx[31:0];
        if (v < -mx) return 32'(-mx);
        return v[31:0];
    endfunction

    mcl_pkg::mcl_state_t st_r;
    logic [1:0] sx;
    logic signed [31:0] vset_r, cset_r, sp, act, e, p, y, acc_n;
    logic [31:0] kp, tn, emax, ymax;
    logic signed [95:0] prod;
    always_comb begin
        sx = st_r == mcl_pkg::ST_POS ? 2'd0
           : st_r == mcl_pkg::ST_VEL ? 2'd1 : 2'd2;
        kp = {16'h0000, regs_r[16 + 4*sx][15:0]};
        tn = regs_r[17 + 4*sx];
        emax = {1'b0, regs_r[18 + 4*sx][30:0]};
        ymax = sx == 2'd1 ? eff_max : regs_r[19 + 4*sx];
        case (sx)
            2'd0: begin
                sp = dpos;
                act = ACT_POS_I;
            end
            2'd1: begin
                sp = vset_r;
                act = ACT_VEL_I;
            end
            default: begin
                sp = cset_r;
                act = ACT_CUR_I;
            end
        endcase
        e = sat(64'(sp) - 64'(act), emax);
        prod = 96'(e) * $signed({64'h0, ymax}) *
               $signed({64'h0, kp});
        if (emax == 32'h0000_0000) begin
            p = 32'sh0000_0000;
        end else begin
            p = sat(64'(prod / $signed(96'(emax) * 96'(mcl_pkg::PCT_FULL))),
                    ymax);
        end
        if (tn == 32'h0000_0000) begin
            acc_n = 32'sh0000_0000;
        end else begin
            acc_n = sat(64'(acc_r[sx]) + 64'(p) / $signed({32'h0, tn}),
                        ymax);
        end
        y = sat(64'(p) + 64'(acc_n), ymax);
    end

    // ----------------------------------------
    // cascade sequencer
    // ----------------------------------------
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_r <= mcl_pkg::ST_IDLE;
            vset_r <= 32'sh0000_0000;
            cset_r <= 32'sh0000_0000;
            for (int s = 0; s < 3; s++) begin
                acc_r[s] <= 32'sh0000_0000;
            end
            PWM_O <= 32'sh0000_0000;
            CUR_SET_O <= 32'sh0000_0000;
        end else begin
            case (st_r)
                mcl_pkg::ST_IDLE: begin
                    if (tick && ctrl[0]) begin
                        if (!closed) begin
                            cset_r <= reduce_r ? sat(64'($signed(
                                regs_r[mcl_pkg::A_REDUCE[6:2]])), eff_max)
                                : $signed(eff_max);
                            st_r <= mcl_pkg::ST_CUR;
                        end else if (pos_act) begin
                            st_r <= mcl_pkg::ST_POS;
                        end else if (vel_act) begin
                            vset_r <= $signed(regs_r[mcl_pkg::A_TVEL[6:2]]);
                            st_r <= mcl_pkg::ST_VEL;
                        end else begin
                            cset_r <= sat(64'($signed(
                                regs_r[mcl_pkg::A_TCUR[6:2]])), eff_max);
                            st_r <= mcl_pkg::ST_CUR;
                        end
                    end
                end
                mcl_pkg::ST_POS: begin
                    acc_r[0] <= acc_n;
                    vset_r <= y;
                    st_r <= mcl_pkg::ST_VEL;
                end
                mcl_pkg::ST_VEL: begin
                    acc_r[1] <= acc_n;
                    cset_r <= y;
                    st_r <= mcl_pkg::ST_CUR;
                end
                mcl_pkg::ST_CUR: begin
                    acc_r[2] <= acc_n;
                    PWM_O <= y;
                    CUR_SET_O <= cset_r;
                    st_r <= mcl_pkg::ST_IDLE;
                end
                default: st_r <= mcl_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ELEC_ANGLE_O <= 16'h0000;
            REDUCE_O <= 1'b0;
        end else begin
            ELEC_ANGLE_O <= 16'(dpos *
                $signed({1'b0, regs_r[mcl_pkg::A_POLES[6:2]][15:0]}));
            REDUCE_O <= reduce_r;
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    logic [4:0] ri;
    assign ri = S_AXI_ARADDR_I[6:2];
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= 2'b00;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RRESP_O <= 2'b00;
            if (S_AXI_ARADDR_I == mcl_pkg::A_STATUS) begin
                S_AXI_RDATA_O <= {27'h0, new_par_r, vel_act, pos_act,
                                  closed, reduce_r};
            end else if (S_AXI_ARADDR_I == mcl_pkg::A_DPOS) begin
                S_AXI_RDATA_O <= dpos;
            end else if (S_AXI_ARADDR_I == mcl_pkg::A_PWM) begin
                S_AXI_RDATA_O <= PWM_O;
            end else if (S_AXI_ARADDR_I < mcl_pkg::A_STATUS &&
                         S_AXI_ARADDR_I[1:0] == 2'b00) begin
                S_AXI_RDATA_O <= regs_r[ri];
            end else begin
                S_AXI_RDATA_O <= 32'h0000_0000;
                S_AXI_RRESP_O <= 2'b10;
            end
        end else if (S_AXI_RREADY_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!ARST_N_I);

    property p_clamp;
        wr_go && wr_ok && wi == mcl_pkg::A_PERMILLE[6:2] &&
        wval > mcl_pkg::PERMILLE_MAX
        |=> regs_r[mcl_pkg::A_PERMILLE[6:2]] == mcl_pkg::PERMILLE_MAX;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("permille not clamped");

    property p_red_gate;
        REDUCE_O |-> $past(submode[mcl_pkg::SM_RED], 2) && !$past(closed, 2);
    endproperty
    a_red_gate: assert property (p_red_gate)
        else $error("reduction while disabled");

    property p_red_idle;
        $rose(reduce_r) |-> $past(idle_r) >= $past(regs_r[7]);
    endproperty
    a_red_idle: assert property (p_red_idle)
        else $error("reduction before idle time");

    property p_pwm_lim;
        $changed(PWM_O) |-> PWM_O <= $signed({1'b0, regs_r[27][30:0]})
            && PWM_O >= -$signed({1'b0, regs_r[27][30:0]});
    endproperty
    a_pwm_lim: assert property (p_pwm_lim)
        else $error("pwm beyond ceiling");

    property p_cur_lim;
        st_r == mcl_pkg::ST_CUR |-> cset_r <= $signed(lim);
    endproperty
    a_cur_lim: assert property (p_cur_lim)
        else $error("current set above limit");

    property p_tn_zero;
        st_r == mcl_pkg::ST_CUR && tn == 32'h0 |=> acc_r[2] == 32'sh0;
    endproperty
    a_tn_zero: assert property (p_tn_zero)
        else $error("integral with zero reset time");

    property p_order;
        st_r == mcl_pkg::ST_POS |=> st_r == mcl_pkg::ST_VEL
            ##1 st_r == mcl_pkg::ST_CUR ##1 st_r == mcl_pkg::ST_IDLE;
    endproperty
    a_order: assert property (p_order)
        else $error("cascade order broken");

    property p_pos_skip;
        st_r == mcl_pkg::ST_IDLE && tick && ctrl[0] && closed && !pos_act
        |=> st_r != mcl_pkg::ST_POS;
    endproperty
    a_pos_skip: assert property (p_pos_skip)
        else $error("position stage ran when inactive");

    property p_vel_skip;
        st_r == mcl_pkg::ST_IDLE && tick && ctrl[0] && closed && !vel_act
        |=> st_r == mcl_pkg::ST_CUR;
    endproperty
    a_vel_skip: assert property (p_vel_skip)
        else $error("velocity stage in real torque");
endmodule // mcl_core
`default_nettype wire

//--- common/mcl_pkg.sv
package mcl_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SUBMODE = 8'h04;
    localparam logic [7:0] A_OPMODE = 8'h08;
    localparam logic [7:0] A_POLES = 8'h0C;
    localparam logic [7:0] A_LIMIT = 8'h10;
    localparam logic [7:0] A_RATED = 8'h14;
    localparam logic [7:0] A_PERMILLE = 8'h18;
    localparam logic [7:0] A_IDLE = 8'h1C;
    localparam logic [7:0] A_REDUCE = 8'h20;
    localparam logic [7:0] A_CDMUL = 8'h24;
    localparam logic [7:0] A_CDDIV = 8'h28;
    localparam logic [7:0] A_LEGACY = 8'h2C;
    localparam logic [7:0] A_TPOS = 8'h30;
    localparam logic [7:0] A_TVEL = 8'h34;
    localparam logic [7:0] A_TCUR = 8'h38;
    localparam logic [7:0] A_STAGE = 8'h40;
    localparam logic [7:0] A_STATUS = 8'h70;
    localparam logic [7:0] A_DPOS = 8'h74;
    localparam logic [7:0] A_PWM = 8'h78;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int SM_LOOP = 0;
    localparam int SM_VPOS = 1;
    localparam int SM_RED = 3;
    localparam int SM_RTQ = 5;
    localparam int LG_CL = 0;
    localparam int LG_OL = 1;
    localparam logic [31:0] PERMILLE_MAX = 32'h0000_03E8;
    localparam logic [31:0] PCT_FULL = 32'h0000_0064;
    localparam logic [31:0] RST_POLES = 32'h0000_0032;
    localparam logic [31:0] RST_LEGACY = 32'h0000_0003;
    localparam logic [31:0] RST_ONE = 32'h0000_0001;
    // operating mode codes
    localparam logic [7:0] OM_PP = 8'h01;
    localparam logic [7:0] OM_VL = 8'h02;
    localparam logic [7:0] OM_PV = 8'h03;
    localparam logic [7:0] OM_TQ = 8'h04;
    localparam logic [7:0] OM_HM = 8'h06;
    localparam logic [7:0] OM_IP = 8'h07;
    localparam logic [7:0] OM_CSP = 8'h08;
    localparam logic [7:0] OM_CSV = 8'h09;
    localparam logic [7:0] OM_CST = 8'h0A;
    localparam logic [7:0] OM_CD = 8'hFF;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int PERIOD_US = 50;
    localparam int MS_US = 1000;
    localparam int PERIOD_CYC = PERIOD_US * CLK_MHZ;
    localparam int MS_CYC = MS_US * CLK_MHZ;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_POS = 4'b0010,
        ST_VEL = 4'b0100,
        ST_CUR = 4'b1000
    } mcl_state_t;
endpackage

//--- test/mcl_motor.sv
`timescale 1ns/1ps
`default_nettype none
module mcl_motor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic signed [31:0] pwm_i,
    output logic signed [31:0] cur_o,
    output logic signed [31:0] vel_o,
    output logic signed [31:0] pos_o
);
    // windings lag the drive by one clock cycle, so loops never see an instant echo
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_o <= '0;
            vel_o <= '0;
            pos_o <= '0;
        end else begin
            cur_o <= pwm_i >>> 2;
            vel_o <= vel_o + (cur_o >>> 4) - (vel_o >>> 3);
            pos_o <= pos_o + (vel_o >>> 4);
        end
    end
endmodule // mcl_motor
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic CLOCK_I = 1'b0;
    logic ARST_N_I = 1'b0;
    logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
    logic [31:0] S_AXI_WDATA_I = 32'h0;
    logic [3:0] S_AXI_WSTRB_I = 4'hF;
    logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0;
    logic S_AXI_BREADY_I = 1'b0, S_AXI_ARVALID_I = 1'b0;
    logic S_AXI_RREADY_I = 1'b0, STEP_I = 1'b0, DIR_I = 1'b0;
    logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, REDUCE_O;
    logic S_AXI_ARREADY_O, S_AXI_RVALID_O;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, rsp;
    logic [31:0] S_AXI_RDATA_O, rdv;
    logic signed [31:0] PWM_O, CUR_SET_O, ACT_POS_I, ACT_VEL_I, ACT_CUR_I;
    logic [15:0] ELEC_ANGLE_O;
    int err_count = 0;
    int checked = 0;
    always #5 CLOCK_I = ~CLOCK_I;
    mcl_core #(.PERIOD_CYC(16), .MS_CYC(20)) mcl_core_inst (
        .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I),
        .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
        .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WDATA_I(S_AXI_WDATA_I),
        .S_AXI_WSTRB_I(S_AXI_WSTRB_I), .S_AXI_WVALID_I(S_AXI_WVALID_I),
        .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
        .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
        .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
        .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
        .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
        .S_AXI_RREADY_I(S_AXI_RREADY_I), .ACT_POS_I(ACT_POS_I),
        .ACT_VEL_I(ACT_VEL_I), .ACT_CUR_I(ACT_CUR_I), .STEP_I(STEP_I),
        .DIR_I(DIR_I), .PWM_O(PWM_O), .CUR_SET_O(CUR_SET_O),
        .ELEC_ANGLE_O(ELEC_ANGLE_O), .REDUCE_O(REDUCE_O));
    mcl_motor mcl_motor_inst (.clk_i(CLOCK_I), .rst_n_i(ARST_N_I),
        .pwm_i(PWM_O), .cur_o(ACT_CUR_I), .vel_o(ACT_VEL_I),
        .pos_o(ACT_POS_I));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK_I);
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= d;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I <= 1'b1;
        S_AXI_BREADY_I <= 1'b1;
        do begin
            @(posedge CLOCK_I);
            if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
            if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
        end while (!S_AXI_BVALID_O);
        rsp = S_AXI_BRESP_O;
        S_AXI_BREADY_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLOCK_I);
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I <= 1'b1;
        do @(posedge CLOCK_I); while (!S_AXI_ARREADY_O);
        S_AXI_ARVALID_I <= 1'b0;
        do @(posedge CLOCK_I); while (!S_AXI_RVALID_O);
        rdv = S_AXI_RDATA_O;
        rsp = S_AXI_RRESP_O;
        S_AXI_RREADY_I <= 1'b0;
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge CLOCK_I);
        ARST_N_I <= 1'b1;
        rd(mcl_pkg::A_POLES);
        chk(rdv, mcl_pkg::RST_POLES);
        wr(mcl_pkg::A_PERMILLE, 32'h7D0);
        rd(mcl_pkg::A_PERMILLE);
        chk(rdv, mcl_pkg::PERMILLE_MAX);
        wr(mcl_pkg::A_STATUS, 32'h1);
        chk({30'h0, rsp}, 32'h2);
        rd(8'h7C);
        chk({30'h0, rsp}, 32'h2);
        $display("test registers done");
        wr(mcl_pkg::A_LIMIT, 32'h12C);
        wr(mcl_pkg::A_RATED, 32'h3E8);
        wr(mcl_pkg::A_CTRL, 32'h1);
        repeat (100) @(posedge CLOCK_I);
        chk(CUR_SET_O, 32'h12C);
        wr(mcl_pkg::A_LIMIT, 32'h7D0);
        wr(mcl_pkg::A_PERMILLE, 32'h190);
        repeat (100) @(posedge CLOCK_I);
        chk(CUR_SET_O, 32'h190);
        wr(mcl_pkg::A_REDUCE, 32'h64);
        wr(mcl_pkg::A_IDLE, 32'h1);
        wr(mcl_pkg::A_SUBMODE, 32'h8);
        repeat (200) @(posedge CLOCK_I);
        chk({31'h0, REDUCE_O}, 32'h1);
        chk(CUR_SET_O, 32'h64);
        wr(mcl_pkg::A_TPOS, 32'h1);
        repeat (3) @(posedge CLOCK_I);
        chk({31'h0, REDUCE_O}, 32'h0);
        chk({16'h0, ELEC_ANGLE_O}, 32'h32);
        repeat (100) @(posedge CLOCK_I);
        chk({31'h0, REDUCE_O}, 32'h1);
        $display("test open loop done");
        wr(mcl_pkg::A_SUBMODE, 32'h1);
        wr(mcl_pkg::A_OPMODE, {24'h0, mcl_pkg::OM_PP});
        rd(mcl_pkg::A_STATUS);
        chk({28'h0, rdv[3:0]}, 32'hE);
        wr(mcl_pkg::A_SUBMODE, 32'h21);
        wr(mcl_pkg::A_OPMODE, {24'h0, mcl_pkg::OM_TQ});
        rd(mcl_pkg::A_STATUS);
        chk({28'h0, rdv[3:0]}, 32'h2);
        wr(mcl_pkg::A_TCUR, 32'h190);
        wr(mcl_pkg::A_STAGE + 8'h20, 32'h64);
        wr(mcl_pkg::A_STAGE + 8'h28, 32'h10);
        wr(mcl_pkg::A_STAGE + 8'h2C, 32'h20);
        repeat (50) @(posedge CLOCK_I);
        chk(PWM_O, 32'h20);
        wr(mcl_pkg::A_STAGE + 8'h20, 32'h32);
        repeat (50) @(posedge CLOCK_I);
        chk(PWM_O, 32'h10);
        wr(mcl_pkg::A_SUBMODE, 32'h3);
        wr(mcl_pkg::A_OPMODE, {24'h0, mcl_pkg::OM_PV});
        rd(mcl_pkg::A_STATUS);
        chk({28'h0, rdv[3:0]}, 32'hE);
        $display("test loop modes done");
        wr(mcl_pkg::A_OPMODE, {24'h0, mcl_pkg::OM_CD});
        repeat (6) begin
            STEP_I <= ~STEP_I;
            repeat (4) @(posedge CLOCK_I);
        end
        rd(mcl_pkg::A_DPOS);
        chk(rdv, 32'h3);
        chk({16'h0, ELEC_ANGLE_O}, 32'h96);
        $display("test step input done");
        summarize;
    end
    // about 750 cycles expected; twenty times that cuts a hang
    initial begin
        #150us;
        err_count++;
        summarize;
    end
endmodule // tb
`default_nettype wire
